/* File: csr_core_regs.sv */
// Core status and option register bank with flag logic and address forming
module csr_core_regs
   import csr_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire csr_instr_t  instr,
   input  wire logic        por_event,
   input  wire logic        watchdog_clear_instr,
   input  wire logic        sleep_instr,
   input  wire logic        watchdog_timeout,
   input  wire logic [7:0]  fsr_ptr,
   output logic [7:0]       result_ff,
   output logic             result_we_ff,
   output logic [7:0]       status_ff,
   output logic [7:0]       option_ff,
   output csr_option_t      opt_cfg_ff,
   output logic [8:0]       direct_addr_ff,
   output logic [8:0]       indirect_addr_ff
);

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic hits(input logic [8:0] a, input logic [8:0] ofs);
      hits = ((a & {2'b00, CSR_BANK_MASK}) == ofs);
   endfunction

   function automatic logic [8:0] pow2(input logic [2:0] n);
      pow2 = 9'h001 << n;
   endfunction

   function automatic logic [7:0] pow2_8(input logic [2:0] n);
      pow2_8 = 8'h01 << n;
   endfunction

   // ****************************************
   // Datapath
   // ****************************************
   logic [8:0] sum9;
   logic [4:0] nib5;
   logic [7:0] nxt_result;
   logic       nxt_we;
   logic       upd_z;
   logic       upd_cdc;
   logic       upd_c_only;
   logic       new_c;
   logic       is_status;
   logic       is_option;
   logic [7:0] opnd_b;
   logic       sub;

   always_comb
   begin
      is_status  = instr.valid && hits(instr.addr, CSR_STATUS_OFS);
      is_option  = instr.valid && (instr.addr[7:0] == CSR_OPTION_OFS[7:0]) && instr.addr[7];
      sub        = (instr.op == CSR_OP_SUB);
      opnd_b     = sub ? (~instr.wreg + 8'h01) : instr.wreg;
      sum9       = {1'b0, instr.src} + {1'b0, opnd_b};
      nib5       = {1'b0, instr.src[CSR_NIB_MSB:0]} + {1'b0, opnd_b[CSR_NIB_MSB:0]};
      if (sub && (instr.wreg == 8'h00))
      begin
         sum9[8] = 1'b1;
         nib5[4] = 1'b1;
      end
      nxt_result = instr.src;
      nxt_we     = instr.valid;
      upd_z      = 1'b0;
      upd_cdc    = 1'b0;
      upd_c_only = 1'b0;
      new_c      = 1'b0;
      case (instr.op)
         CSR_OP_NONE:   nxt_we = 1'b0;
         CSR_OP_MOVE:   nxt_result = instr.wreg;
         CSR_OP_ADD, CSR_OP_SUB:
         begin
            nxt_result = sum9[7:0];
            upd_z      = 1'b1;
            upd_cdc    = 1'b1;
         end
         CSR_OP_AND:    begin nxt_result = instr.src & instr.wreg; upd_z = 1'b1; end
         CSR_OP_IOR:    begin nxt_result = instr.src | instr.wreg; upd_z = 1'b1; end
         CSR_OP_XOR:    begin nxt_result = instr.src ^ instr.wreg; upd_z = 1'b1; end
         CSR_OP_INCDEC: begin nxt_result = instr.src + instr.wreg; upd_z = 1'b1; end
         CSR_OP_CLR:    begin nxt_result = 8'h00; upd_z = 1'b1; end
         CSR_OP_RRF:
         begin
            nxt_result = {status_ff[CSR_C_BIT], instr.src[7:1]};
            new_c      = instr.src[0];
            upd_c_only = 1'b1;
         end
         CSR_OP_RLF:
         begin
            nxt_result = {instr.src[6:0], status_ff[CSR_C_BIT]};
            new_c      = instr.src[7];
            upd_c_only = 1'b1;
         end
         CSR_OP_SWAP:   nxt_result = {instr.src[3:0], instr.src[7:4]};
         CSR_OP_BCF:    nxt_result = instr.src & ~(8'h01 << instr.bit_sel);
         CSR_OP_BSF:    nxt_result = instr.src | (8'h01 << instr.bit_sel);
         default:       nxt_we = 1'b0;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         result_ff    <= 8'h00;
         result_we_ff <= 1'b0;
      end
      else
      begin
         result_ff    <= nxt_result;
         result_we_ff <= nxt_we && !is_status && !is_option;
      end
   end

   // ****************************************
   // Status register
   // ****************************************
   logic [7:0] nxt_status;

   always_comb
   begin
      nxt_status = status_ff;
      if (is_status && nxt_we)
      begin
         nxt_status = (status_ff & ~CSR_STATUS_WMASK) | (nxt_result & CSR_STATUS_WMASK);
         if (upd_cdc)
         begin
            nxt_status[CSR_DC_BIT] = status_ff[CSR_DC_BIT];
            nxt_status[CSR_C_BIT]  = status_ff[CSR_C_BIT];
         end
         if (upd_c_only)
         begin
            nxt_status[CSR_C_BIT] = status_ff[CSR_C_BIT];
         end
         // Clearing status keeps both carry flags
         if (instr.op == CSR_OP_CLR)
         begin
            nxt_status[CSR_DC_BIT] = status_ff[CSR_DC_BIT];
            nxt_status[CSR_C_BIT]  = status_ff[CSR_C_BIT];
         end
      end
      if (upd_z && instr.valid)
      begin
         nxt_status[CSR_Z_BIT] = (nxt_result == 8'h00);
      end
      if (upd_cdc && instr.valid)
      begin
         nxt_status[CSR_DC_BIT] = nib5[4];
         nxt_status[CSR_C_BIT]  = sum9[8];
      end
      if (upd_c_only && instr.valid)
      begin
         nxt_status[CSR_C_BIT] = new_c;
      end
      if (por_event || watchdog_clear_instr)
      begin
         nxt_status[CSR_TO_BIT] = 1'b1;
         nxt_status[CSR_PD_BIT] = 1'b1;
      end
      else if (sleep_instr)
      begin
         nxt_status[CSR_TO_BIT] = 1'b1;
         nxt_status[CSR_PD_BIT] = 1'b0;
      end
      else if (watchdog_timeout)
      begin
         nxt_status[CSR_TO_BIT] = 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         status_ff <= CSR_STATUS_RST;
      end
      else
      begin
         status_ff <= nxt_status;
      end
   end

   // ****************************************
   // Option register
   // ****************************************
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         option_ff <= CSR_OPTION_RST;
      end
      else if (is_option && nxt_we)
      begin
         option_ff <= nxt_result;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         opt_cfg_ff <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 9'h100, 8'h80};
      end
      else
      begin
         opt_cfg_ff.pullup_off  <= option_ff[CSR_PU_BIT];
         opt_cfg_ff.irq_rising  <= option_ff[CSR_EDGE_BIT];
         opt_cfg_ff.t0_from_pin <= option_ff[CSR_SRC_BIT];
         opt_cfg_ff.t0_falling  <= option_ff[CSR_T0E_BIT];
         opt_cfg_ff.psc_to_wdt  <= option_ff[CSR_PSA_BIT];
         // Except for the reset value, which divides both, only the assigned consumer sees division; the other runs 1:1
         opt_cfg_ff.t0_div <= option_ff[CSR_PSA_BIT] ? 9'h001
                              : (pow2(option_ff[CSR_PS_HI:0]) << 1);
         opt_cfg_ff.wdt_div <= option_ff[CSR_PSA_BIT]
                              ? pow2_8(option_ff[CSR_PS_HI:0]) : 8'h01;
      end
   end

   // ****************************************
   // Address forming
   // ****************************************
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         direct_addr_ff   <= 9'h000;
         indirect_addr_ff <= 9'h000;
      end
      else
      begin
         direct_addr_ff   <= {status_ff[CSR_RP_HI:CSR_RP_LO], instr.addr[6:0]};
         indirect_addr_ff <= {status_ff[CSR_IRP_BIT], fsr_ptr};
      end
   end

endmodule

/* File: csr_pkg.sv */
// Constants and types for the core status and option register bank
// Overview of operation
// - Flag-setting ops override data write to flags
// - Instruction writes never change expiry/sleep flags
// - Indirect bank bit selects banks 2-3
// - Direct bank bits select one of four banks
// - Expiry flag set by clear/sleep, cleared timeout
// - Sleep flag set by clear, cleared by sleep
// - Zero flag follows zero result
// - Nibble carry from bit 3, inverted borrow
// - Carry from MSB, inverted borrow on subtract
// - Subtract adds two's complement of operand
// - Rotates load carry from source end bit
// - Clearing status zeroes banks, sets zero flag
// - Status decodes in every bank, option in banks 1 and 3 only
// - Pull-up disable bit kills all pull-ups
// - Edge select picks external interrupt edge
// - Source bit picks pin or instruction clock
// - Pin edge bit picks counting transition
// - One prescaler, assigned timer or watchdog; reset value divides both
// - Rate field doubles division per step
package csr_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [8:0] CSR_STATUS_OFS = 9'h003;
   localparam logic [8:0] CSR_OPTION_OFS = 9'h081;
   localparam logic [6:0] CSR_BANK_MASK  = 7'h7F;
   localparam logic [7:0] CSR_OPTION_RST = 8'hFF;
   localparam logic [7:0] CSR_STATUS_RST = 8'h18;
   localparam logic [7:0] CSR_OPTION_ALT = 8'h81;

   // ****************************************
   // Status field positions
   // ****************************************
   localparam int CSR_IRP_BIT = 7;
   localparam int CSR_RP_HI   = 6;
   localparam int CSR_RP_LO   = 5;
   localparam int CSR_TO_BIT  = 4;
   localparam int CSR_PD_BIT  = 3;
   localparam int CSR_Z_BIT   = 2;
   localparam int CSR_DC_BIT  = 1;
   localparam int CSR_C_BIT   = 0;
   localparam int CSR_NIB_MSB = 3;
   localparam logic [7:0] CSR_STATUS_WMASK = 8'hE7;

   // ****************************************
   // Option field positions
   // ****************************************
   localparam int CSR_PU_BIT   = 7;
   localparam int CSR_EDGE_BIT = 6;
   localparam int CSR_SRC_BIT  = 5;
   localparam int CSR_T0E_BIT  = 4;
   localparam int CSR_PSA_BIT  = 3;
   localparam int CSR_PS_HI    = 2;

   // ****************************************
   // ALU operations
   // ****************************************
   typedef enum logic [3:0]
   {
      CSR_OP_NONE  = 4'h0,
      CSR_OP_MOVE  = 4'h1,
      CSR_OP_ADD   = 4'h2,
      CSR_OP_SUB   = 4'h3,
      CSR_OP_AND   = 4'h4,
      CSR_OP_IOR   = 4'h5,
      CSR_OP_XOR   = 4'h6,
      CSR_OP_CLR   = 4'h7,
      CSR_OP_RRF   = 4'h8,
      CSR_OP_RLF   = 4'h9,
      CSR_OP_SWAP  = 4'hA,
      CSR_OP_BCF   = 4'hB,
      CSR_OP_BSF   = 4'hC,
      CSR_OP_INCDEC = 4'hD
   } csr_op_t;

   typedef struct packed
   {
      logic       valid;
      csr_op_t    op;
      logic [8:0] addr;
      logic [7:0] src;
      logic [7:0] wreg;
      logic [2:0] bit_sel;
   } csr_instr_t;

   typedef struct packed
   {
      logic       pullup_off;
      logic       irq_rising;
      logic       t0_from_pin;
      logic       t0_falling;
      logic       psc_to_wdt;
      logic [8:0] t0_div;
      logic [7:0] wdt_div;
   } csr_option_t;

endpackage

/* File: csr_core_regs_props.sv */
// Concurrent checks on the core status and option register bank
module csr_core_regs_props
   import csr_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst_n,
   input wire csr_instr_t  instr,
   input wire logic        por_event,
   input wire logic        watchdog_clear_instr,
   input wire logic        sleep_instr,
   input wire logic        watchdog_timeout,
   input wire logic [7:0]  fsr_ptr,
   input wire logic [7:0]  result_ff,
   input wire logic        result_we_ff,
   input wire logic [7:0]  status_ff,
   input wire logic [7:0]  option_ff,
   input wire csr_option_t opt_cfg_ff,
   input wire logic [8:0]  direct_addr_ff,
   input wire logic [8:0]  indirect_addr_ff
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire logic clr_ev = por_event | watchdog_clear_instr;
   wire logic any_ev = clr_ev | sleep_instr | watchdog_timeout;
   wire logic op_ok  = instr.valid && !any_ev;

   property p_ro_flags;
      $past(rst_n) && !$past(any_ev) |-> status_ff[4:3] == $past(status_ff[4:3]);
   endproperty
   a_ro_flags: assert property (p_ro_flags) else $error("flags moved");
   property p_sleep;
      sleep_instr && !clr_ev |=> status_ff[4:3] == 2'b10;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep flags wrong");
   property p_clear;
      clr_ev |=> status_ff[4:3] == 2'b11;
   endproperty
   a_clear: assert property (p_clear) else $error("clear flags wrong");
   property p_tmo;
      watchdog_timeout && !clr_ev && !sleep_instr |=> status_ff[4:3] == {1'b0, $past(status_ff[3])};
   endproperty
   a_tmo: assert property (p_tmo) else $error("timeout flags wrong");
   property p_zero;
      op_ok && instr.op inside {CSR_OP_ADD, CSR_OP_SUB, CSR_OP_AND, CSR_OP_IOR, CSR_OP_XOR}
      |=> status_ff[2] == (result_ff == 8'h00);
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong");
   property p_add;
      op_ok && instr.op == CSR_OP_ADD |=>
      {status_ff[0], result_ff} == {1'b0, $past(instr.src)} + {1'b0, $past(instr.wreg)} &&
      status_ff[1] == ({1'b0, $past(instr.src[3:0])} + $past(instr.wreg[3:0]) > 5'd15);
   endproperty
   a_add: assert property (p_add) else $error("add carries wrong");
   property p_sub;
      op_ok && instr.op == CSR_OP_SUB |=>
      {status_ff[0], result_ff} == {1'b0, $past(instr.src)} + {1'b0, ~$past(instr.wreg)} + 9'h001;
   endproperty
   a_sub: assert property (p_sub) else $error("subtract carry wrong");
   property p_rot;
      op_ok && instr.op inside {CSR_OP_RRF, CSR_OP_RLF} |=> status_ff[0] ==
      ($past(instr.op) == CSR_OP_RRF ? $past(instr.src[0]) : $past(instr.src[7]));
   endproperty
   a_rot: assert property (p_rot) else $error("rotate carry wrong");
   property p_clr_stat;
      op_ok && instr.op == CSR_OP_CLR && instr.addr[6:0] == 7'h03 |=>
      status_ff == {3'b000, $past(status_ff[4:3]), 1'b1, $past(status_ff[1:0])};
   endproperty
   a_clr_stat: assert property (p_clr_stat) else $error("status clear wrong");
   property p_no_we;
      instr.valid && (instr.addr[6:0] == 7'h03 || instr.addr[7:0] == 8'h81) |=> !result_we_ff;
   endproperty
   a_no_we: assert property (p_no_we) else $error("held register written out");
   property p_addr;
      $past(rst_n) && $stable(status_ff) |-> indirect_addr_ff == {status_ff[7], $past(fsr_ptr)}
      && direct_addr_ff == {status_ff[6:5], $past(instr.addr[6:0])};
   endproperty
   a_addr: assert property (p_addr) else $error("address forming wrong");
   property p_opt;
      $past(rst_n) && $stable(option_ff) |-> opt_cfg_ff == {option_ff[7:3],
      (option_ff[3] ? 9'h001 : 9'h002 << option_ff[2:0]),
      (option_ff[3] ? 8'h01 << option_ff[2:0] : 8'h01)};
   endproperty
   a_opt: assert property (p_opt) else $error("option decode wrong");
   c_sub: cover property (op_ok && instr.op == CSR_OP_SUB);
   c_sleep: cover property (sleep_instr && !clr_ev);
   c_opt: cover property (instr.valid && instr.addr == 9'h181);
endmodule

bind csr_core_regs csr_core_regs_props u_props (.clk(clk), .rst_n(rst_n), .instr(instr),
   .por_event(por_event), .watchdog_clear_instr(watchdog_clear_instr),
   .sleep_instr(sleep_instr), .watchdog_timeout(watchdog_timeout), .fsr_ptr(fsr_ptr),
   .result_ff(result_ff), .result_we_ff(result_we_ff), .status_ff(status_ff),
   .option_ff(option_ff), .opt_cfg_ff(opt_cfg_ff), .direct_addr_ff(direct_addr_ff),
   .indirect_addr_ff(indirect_addr_ff));

/* File: csr_dp_model.sv */
// Datapath model that fetches the status or option value into instructions that target them
module csr_dp_model
   import csr_pkg::*;
(
   input  wire csr_instr_t req,
   input  wire logic [7:0] status_ff,
   input  wire logic [7:0] option_ff,
   output csr_instr_t      instr
);
   timeunit 1ns;
   timeprecision 100ps;
   // Port direction register lives beyond this model
   always_comb
   begin
      instr = req;
      if (req.addr[6:0] == 7'h03)
         instr.src = status_ff;
      else if (req.addr[7:0] == 8'h81)
         instr.src = option_ff;
   end
endmodule

/* File: csr_core_regs_tb.sv */
// Self-checking bench for the core status and option register bank
module csr_core_regs_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import csr_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [3:0]  ev = 4'h0;
   logic [7:0]  fsr_ptr = 8'h00;
   csr_instr_t  req = '0;
   csr_instr_t  instr;
   logic [7:0]  result_ff, status_ff, option_ff;
   logic        result_we_ff;
   csr_option_t opt_cfg_ff;
   logic [8:0]  direct_addr_ff, indirect_addr_ff;
   int          errors = 0;
   int          samples_checked = 0;

   always #12.5 clk = ~clk;
   csr_dp_model u_dp (.req(req), .status_ff(status_ff), .option_ff(option_ff), .instr(instr));
   csr_core_regs DUT (.clk(clk), .rst_n(rst_n), .instr(instr), .por_event(ev[3]),
      .watchdog_clear_instr(ev[2]), .sleep_instr(ev[1]), .watchdog_timeout(ev[0]),
      .fsr_ptr(fsr_ptr), .result_ff(result_ff), .result_we_ff(result_we_ff),
      .status_ff(status_ff), .option_ff(option_ff), .opt_cfg_ff(opt_cfg_ff),
      .direct_addr_ff(direct_addr_ff), .indirect_addr_ff(indirect_addr_ff));

   task automatic chk(input logic [21:0] got, input logic [21:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic run(input csr_op_t op, input logic [8:0] a, input logic [7:0] s, w);
      @(posedge clk);
      req <= '{1'b1, op, a, s, w, 3'h0};
      @(posedge clk);
      req.valid <= 1'b0;
      #1;
   endtask
   task automatic alu(input csr_op_t op, input logic [7:0] s, w, r, input logic [2:0] f);
      run(op, 9'h020, s, w);
      chk({result_we_ff, result_ff, status_ff[2:0]}, {1'b1, r, f});
   endtask
   task automatic t_banks();
      logic [7:0] w;
      for (int b = 0; b < 4; b++)
      begin
         w = {b[0], b[1:0], 5'h05};
         fsr_ptr <= {b[1:0], 6'h2A};
         run(CSR_OP_MOVE, {status_ff[6:5], 7'h03}, 8'h00, w);
         chk(status_ff, {w[7:5], 2'b11, w[2:0]});
         run(CSR_OP_NONE, 9'h055, 8'h00, 8'h00);
         chk(direct_addr_ff, {b[1:0], 7'h55});
         chk(indirect_addr_ff, {b[0], b[1:0], 6'h2A});
      end
   endtask
   task automatic t_flags();
      run(CSR_OP_MOVE, 9'h183, 8'h00, 8'h00);
      run(CSR_OP_IOR, 9'h003, 8'h00, 8'h04);
      chk({result_we_ff, status_ff}, 9'h018);
      run(CSR_OP_CLR, 9'h083, 8'h00, 8'h00);
      chk(status_ff, 8'h1C);
      run(CSR_OP_ADD, 9'h103, 8'h00, 8'hE8);
      chk(status_ff, 8'h1B);
      run(CSR_OP_CLR, 9'h003, 8'h00, 8'h00);
      chk(status_ff, 8'h1F);
   endtask
   task automatic t_events();
      logic [3:0] e [6] = '{4'h2, 4'h1, 4'h4, 4'h1, 4'h8, 4'h3};
      logic [1:0] x [6] = '{2'b10, 2'b00, 2'b11, 2'b01, 2'b11, 2'b10};
      for (int i = 0; i < 6; i++)
      begin
         @(posedge clk);
         ev <= e[i];
         @(posedge clk);
         ev <= 4'h0;
         #1;
         chk(status_ff[4:3], x[i]);
      end
   endtask
   task automatic t_option();
      logic [7:0] v;
      for (int i = 0; i < 16; i++)
      begin
         v = {~i[3:0], i[3:0]};
         run(CSR_OP_MOVE, i[0] ? 9'h181 : 9'h081, 8'h00, v);
         chk(option_ff, v);
         @(posedge clk);
         #1;
         chk(opt_cfg_ff, {v[7:3], (v[3] ? 9'h001 : 9'h002 << v[2:0]),
            (v[3] ? 8'h01 << v[2:0] : 8'h01)});
      end
   endtask
   task automatic test_done();
      if (errors == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial
   begin
      #(25 * 3000);
      errors++;
      test_done();
   end
   initial
   begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk({status_ff, option_ff}, 16'h18FF);
      chk(opt_cfg_ff, {5'h1F, 9'h100, 8'h80});
      t_banks();
      t_flags();
      alu(CSR_OP_ADD, 8'h0F, 8'h01, 8'h10, 3'b010);
      alu(CSR_OP_ADD, 8'hF0, 8'h10, 8'h00, 3'b101);
      alu(CSR_OP_ADD, 8'h88, 8'h88, 8'h10, 3'b011);
      alu(CSR_OP_SUB, 8'h05, 8'h05, 8'h00, 3'b111);
      alu(CSR_OP_SUB, 8'h00, 8'h01, 8'hFF, 3'b000);
      alu(CSR_OP_SUB, 8'h10, 8'h01, 8'h0F, 3'b001);
      alu(CSR_OP_SUB, 8'h3C, 8'h00, 8'h3C, 3'b011);
      alu(CSR_OP_AND, 8'h0F, 8'hF0, 8'h00, 3'b111);
      alu(CSR_OP_XOR, 8'h5A, 8'h5A, 8'h00, 3'b111);
      alu(CSR_OP_IOR, 8'h00, 8'h01, 8'h01, 3'b011);
      alu(CSR_OP_SWAP, 8'h3C, 8'h00, 8'hC3, 3'b011);
      alu(CSR_OP_INCDEC, 8'hFF, 8'h01, 8'h00, 3'b111);
      alu(CSR_OP_BSF, 8'h40, 8'h00, 8'h41, 3'b111);
      alu(CSR_OP_BCF, 8'h41, 8'h00, 8'h40, 3'b111);
      run(CSR_OP_RRF, 9'h020, 8'h01, 8'h00);
      chk(status_ff[0], 1'b1);
      run(CSR_OP_RLF, 9'h020, 8'h7F, 8'h00);
      chk(status_ff[0], 1'b0);
      t_events();
      t_option();
      test_done();
   end
endmodule
